// *** design/msr_status_readback.sv ***
// Host-port status byte, signals word and data read-back logic
`timescale 1ns/100ps
`default_nettype none
`include "msr_defs.svh"
module msr_status_readback #(
  parameter logic [3:0] BUSY_CYC = 4'(`MSR_BUSY_CYC)
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset,
  // Host parallel port
  input  wire logic        cs_n,
  input  wire logic        port_select_n,
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  input  wire logic [7:0]  db_in,
  output logic      [7:0]  db_out,
  output logic             db_oe,
  output logic             host_int,
  // Core events and levels
  input  wire logic        core_busy,
  input  wire logic        index_pulse,
  input  wire logic        traj_done,
  input  wire logic        breakpoint_hit,
  input  wire logic        pos_error,
  input  wire logic        wraparound,
  input  wire logic        motor_off,
  input  wire logic        accel_written,
  input  wire logic        sample_end,
  input  wire logic [5:0]  int_mask,
  // Core values
  input  wire logic [31:0] desired_pos,
  input  wire logic [31:0] real_pos,
  input  wire logic [31:0] desired_vel,
  input  wire logic [15:0] real_vel,
  // Mode outputs and start pulse to the core
  output logic             eight_bit_mode,
  output logic             stop_on_error,
  output logic             start_motion
);

  msr_pkg::msr_state_s q;
  msr_pkg::msr_state_s d;
  logic        busy;
  logic        rd_now;
  logic        wr_now;
  logic        rd_take;
  logic        wr_take;
  logic        err_evt;
  logic        idx_evt;
  logic        traj_evt;
  logic        src_now;
  logic [5:0]  ev;
  logic [7:0]  status;
  logic [15:0] signals;
  logic        cmd_ok;

  // Status byte and signals word views of the current state
  assign status  = {motor_off, q.flags, busy};
  assign signals = {q.host_int, q.accel, q.filt_upd, q.fwd, q.vel, q.on_target,
                    q.stop_err, q.eight, status[7:1], q.arm};

  // Command write that the logic below really executes; a status read wins
  assign cmd_ok = wr_take & !port_select_n & !busy & !rd_take;

  // Next state: sample-end clear, then host access, then core events so a set wins a clear, except that an index capture clears arm over an arm command
  always_comb begin
    d        = q;
    busy     = core_busy | (q.busy_cnt != 4'h0);
    rd_now   = !cs_n & !rd_n;
    wr_now   = !cs_n & !wr_n;
    rd_take  = rd_now & !q.rd_act;
    wr_take  = wr_now & !q.wr_act;
    err_evt  = 1'b0;
    d.rd_act = rd_now;
    d.wr_act = wr_now;
    d.db_oe  = rd_now;
    d.start  = 1'b0;
    if (q.busy_cnt != 4'h0) begin
      d.busy_cnt = q.busy_cnt - 4'h1;
    end
    // Filter-update flag lives one sample interval
    if (sample_end) begin
      d.filt_upd = 1'b0;
    end
    if (rd_take & !port_select_n) begin
      // Status read needs no command and is allowed even when busy
      d.db_out = status;
    end else if (!busy) begin
      if (wr_take & !port_select_n) begin
        // Any command ends the old sequence, finished or not
        d.seq      = msr_pkg::ST_IDLE;
        d.left     = 3'h0;
        d.busy_cnt = BUSY_CYC;
        case (db_in)
          `MSR_CMD_CLEAR_INT: begin
            d.flags    = 6'h00;
            d.host_int = 1'b0;
          end
          `MSR_CMD_ARM_INDEX: begin
            d.arm = 1'b1;
          end
          `MSR_CMD_LOAD_TRAJ: begin
            d.seq  = msr_pkg::ST_WRITE;
            d.left = `MSR_BYTES_CTRL;
          end
          `MSR_CMD_START_MOTION: begin
            d.start     = 1'b1;
            d.fwd       = q.pend_fwd;
            d.vel       = q.pend_vel;
            d.on_target = 1'b0;
            d.accel     = 1'b0;
          end
          `MSR_CMD_FILTER_UPDATE: begin
            d.filt_upd = 1'b1;
          end
          `MSR_CMD_STOP_ON_ERR: begin
            d.stop_err = 1'b1;
          end
          `MSR_CMD_INT_ON_ERR: begin
            d.stop_err = 1'b0;
          end
          `MSR_CMD_EIGHT_BIT: begin
            d.eight = 1'b1;
          end
          `MSR_CMD_TWELVE_BIT: begin
            d.eight = 1'b0;
          end
          // Reporting commands snapshot their value, left-justified
          `MSR_CMD_RD_SIGNALS: begin
            d.seq   = msr_pkg::ST_READ;
            d.left  = `MSR_BYTES_SHORT;
            d.shreg = {signals, 16'h0000};
          end
          `MSR_CMD_RD_INDEX_POS: begin
            d.seq   = msr_pkg::ST_READ;
            d.left  = `MSR_BYTES_LONG;
            d.shreg = q.idx_pos;
          end
          `MSR_CMD_RD_DES_POS: begin
            d.seq   = msr_pkg::ST_READ;
            d.left  = `MSR_BYTES_LONG;
            d.shreg = desired_pos;
          end
          `MSR_CMD_RD_REAL_POS: begin
            d.seq   = msr_pkg::ST_READ;
            d.left  = `MSR_BYTES_LONG;
            d.shreg = real_pos;
          end
          `MSR_CMD_RD_DES_VEL: begin
            d.seq   = msr_pkg::ST_READ;
            d.left  = `MSR_BYTES_LONG;
            d.shreg = desired_vel;
          end
          `MSR_CMD_RD_REAL_VEL: begin
            d.seq   = msr_pkg::ST_READ;
            d.left  = `MSR_BYTES_SHORT;
            d.shreg = {real_vel, 16'h0000};
          end
          default: begin
            // Other codes belong to the core; sequence simply ends
          end
        endcase
      end else if (wr_take) begin
        // Data byte write
        case (q.seq)
          msr_pkg::ST_READ: begin
            err_evt = 1'b1;
          end
          msr_pkg::ST_WRITE: begin
            d.busy_cnt = BUSY_CYC;
            if (q.left == `MSR_BYTES_CTRL) begin
              d.pend_fwd = db_in[`MSR_CTRL_FWD_BIT];
              d.pend_vel = db_in[`MSR_CTRL_VEL_BIT];
            end
            d.left = q.left - 3'h1;
            if (q.left == 3'h1) begin
              d.seq = msr_pkg::ST_IDLE;
            end
          end
          default: begin
            // Stray writes outside a sequence go to the core unchecked
          end
        endcase
      end else if (rd_take) begin
        // Data byte read, most significant byte first
        case (q.seq)
          msr_pkg::ST_WRITE: begin
            err_evt = 1'b1;
          end
          msr_pkg::ST_READ: begin
            d.db_out = q.shreg[31:24];
            d.shreg  = {q.shreg[23:0], 8'h00};
            d.left   = q.left - 3'h1;
            if (q.left == 3'h1) begin
              d.seq = msr_pkg::ST_IDLE;
            end
          end
          default: begin
            // Idle read returns the buffer unchanged
          end
        endcase
      end
    end
    // Reads refused while busy leave db_out as it stands
    // Index capture only when armed
    idx_evt = index_pulse & q.arm;
    if (idx_evt) begin
      d.idx_pos = real_pos;
      d.arm     = 1'b0;
    end
    // Trajectory complete follows a rise of motor-off or on-target
    src_now    = motor_off | q.on_target;
    d.traj_src = src_now;
    traj_evt   = src_now & !q.traj_src;
    if (traj_done) begin
      d.on_target = 1'b1;
    end
    if (accel_written) begin
      d.accel = 1'b1;
    end
    // Flags set regardless of mask; mask only gates the pin
    ev       = {breakpoint_hit, pos_error, wraparound, idx_evt, traj_evt, err_evt};
    d.flags  = d.flags | ev;
    if ((ev & int_mask) != 6'h00) begin
      d.host_int = 1'b1;
    end
  end

  // State register
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      q       <= '0;
      q.eight <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from state flip-flops
  assign db_out         = q.db_out;
  assign db_oe          = q.db_oe;
  assign host_int       = q.host_int;
  assign eight_bit_mode = q.eight;
  assign stop_on_error  = q.stop_err;
  assign start_motion   = q.start;

  // Checks on the logic above
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  index_capture_a: assert property (
    index_pulse && q.arm |=> q.flags[2] && !q.arm && q.idx_pos == $past(real_pos))
    else $error("index capture failed");

  traj_flag_a: assert property (
    $rose(motor_off | q.on_target) |=> q.flags[1])
    else $error("trajectory complete flag not set");

  cmd_error_a: assert property (
    rd_take && port_select_n && !busy && q.seq == msr_pkg::ST_WRITE |=> q.flags[0])
    else $error("command error not flagged");

  mask_free_a: assert property (
    pos_error && int_mask == 6'h00 |=> q.flags[4] && !$rose(q.host_int))
    else $error("masked flag handling wrong");

  busy_ignore_a: assert property (
    wr_take && busy |=> $stable(q.seq) && $stable(q.left) && $stable(q.fwd))
    else $error("write accepted while busy");

  busy_read_a: assert property (
    rd_take && port_select_n && busy |=> $stable(q.db_out))
    else $error("busy read changed buffer");

  busy_noerr_a: assert property (
    (rd_take || wr_take) && busy && !q.flags[0] |=> !q.flags[0])
    else $error("busy access flagged error");

  byte_order_a: assert property (
    rd_take && port_select_n && !busy && q.seq == msr_pkg::ST_READ
    |=> q.db_out == $past(q.shreg[31:24]) ##1 q.shreg[31:24] == $past(q.shreg[23:16], 2))
    else $error("read-back byte order wrong");

  int_clear_a: assert property (
    wr_take && !port_select_n && !busy && db_in == `MSR_CMD_CLEAR_INT
    && (ev & int_mask) == 6'h00 |=> !q.host_int && signals[15] == 1'b0)
    else $error("interrupt clear failed");

  start_load_a: assert property (
    wr_take && !port_select_n && !busy && db_in == `MSR_CMD_START_MOTION
    |=> q.fwd == $past(q.pend_fwd) && q.vel == $past(q.pend_vel) && start_motion ##1 !start_motion)
    else $error("start motion did not apply pending mode");

  port_mode_a: assert property (
    wr_take && !port_select_n && !busy && db_in == `MSR_CMD_TWELVE_BIT |=> !eight_bit_mode)
    else $error("twelve-bit command ignored");

  abort_seq_a: assert property (
    wr_take && !port_select_n && !busy && q.seq != msr_pkg::ST_IDLE
    && db_in == `MSR_CMD_ARM_INDEX |=> q.seq == msr_pkg::ST_IDLE && q.arm)
    else $error("new command did not abort sequence");

  arm_set_a: assert property (
    cmd_ok && db_in == `MSR_CMD_ARM_INDEX && !index_pulse |=> q.arm && signals[0])
    else $error("arm command not taken");

  int_set_a: assert property (
    (ev & int_mask) != 6'h00 |=> host_int && signals[15])
    else $error("host interrupt not raised");

  accel_flag_a: assert property (
    accel_written |=> q.accel && signals[14])
    else $error("acceleration flag not set");

  filter_set_a: assert property (
    cmd_ok && db_in == `MSR_CMD_FILTER_UPDATE |=> q.filt_upd && signals[13])
    else $error("filter update flag not set");

  filter_clear_a: assert property (
    sample_end && !cmd_ok |=> !q.filt_upd)
    else $error("filter update flag outlived interval");

  on_target_a: assert property (
    traj_done |=> q.on_target && signals[10])
    else $error("on-target flag not set");

  start_clear_a: assert property (
    cmd_ok && db_in == `MSR_CMD_START_MOTION && !traj_done && !accel_written
    |=> !q.on_target && !q.accel)
    else $error("start motion left flags set");

  stop_set_a: assert property (
    cmd_ok && db_in == `MSR_CMD_STOP_ON_ERR |=> stop_on_error && signals[9])
    else $error("stop-on-error not set");

  stop_clear_a: assert property (
    cmd_ok && db_in == `MSR_CMD_INT_ON_ERR |=> !stop_on_error && !signals[9])
    else $error("stop-on-error not cleared");

  eight_set_a: assert property (
    cmd_ok && db_in == `MSR_CMD_EIGHT_BIT |=> eight_bit_mode && signals[8])
    else $error("eight-bit command ignored");

  status_read_a: assert property (
    rd_take && !port_select_n |=> db_out == $past(status) && db_oe)
    else $error("status byte not returned");

  signals_load_a: assert property (
    cmd_ok && db_in == `MSR_CMD_RD_SIGNALS
    |=> q.shreg[31:16] == $past(signals) && q.left == `MSR_BYTES_SHORT)
    else $error("signals word not loaded");

  index_load_a: assert property (
    cmd_ok && db_in == `MSR_CMD_RD_INDEX_POS
    |=> q.shreg == $past(q.idx_pos) && q.left == `MSR_BYTES_LONG)
    else $error("index position not loaded");

  des_pos_load_a: assert property (
    cmd_ok && db_in == `MSR_CMD_RD_DES_POS
    |=> q.shreg == $past(desired_pos) && q.left == `MSR_BYTES_LONG)
    else $error("desired position not loaded");

  real_pos_load_a: assert property (
    cmd_ok && db_in == `MSR_CMD_RD_REAL_POS
    |=> q.shreg == $past(real_pos) && q.left == `MSR_BYTES_LONG)
    else $error("real position not loaded");

  des_vel_load_a: assert property (
    cmd_ok && db_in == `MSR_CMD_RD_DES_VEL
    |=> q.shreg == $past(desired_vel) && q.left == `MSR_BYTES_LONG)
    else $error("desired velocity not loaded");

  real_vel_load_a: assert property (
    cmd_ok && db_in == `MSR_CMD_RD_REAL_VEL
    |=> q.shreg == {$past(real_vel), 16'h0000} && q.left == `MSR_BYTES_SHORT)
    else $error("real velocity not loaded");

  // Main scenarios
  long_read_c: cover property (
    q.seq == msr_pkg::ST_READ && q.left == `MSR_BYTES_LONG ##[1:100] q.seq == msr_pkg::ST_IDLE);
  index_hit_c: cover property (index_pulse && q.arm);
  err_seen_c: cover property (err_evt);
  busy_reject_c: cover property (wr_take && busy);
  traj_write_c: cover property (wr_take && port_select_n && q.seq == msr_pkg::ST_WRITE);

endmodule
`default_nettype wire

// *** design/msr_defs.svh ***
// Constants for the motion status and read-back block
`ifndef MSR_DEFS_SVH
`define MSR_DEFS_SVH
// Command codes
`define MSR_CMD_START_MOTION     8'h01
`define MSR_CMD_ARM_INDEX        8'h03
`define MSR_CMD_FILTER_UPDATE    8'h04
`define MSR_CMD_EIGHT_BIT        8'h05
`define MSR_CMD_TWELVE_BIT       8'h06
`define MSR_CMD_RD_DES_VEL       8'h07
`define MSR_CMD_RD_DES_POS       8'h08
`define MSR_CMD_RD_INDEX_POS     8'h09
`define MSR_CMD_RD_REAL_POS      8'h0A
`define MSR_CMD_RD_REAL_VEL      8'h0B
`define MSR_CMD_RD_SIGNALS       8'h0C
`define MSR_CMD_STOP_ON_ERR      8'h1A
`define MSR_CMD_INT_ON_ERR       8'h1B
`define MSR_CMD_CLEAR_INT        8'h1D
`define MSR_CMD_LOAD_TRAJ        8'h1F
// Byte counts of sequences
`define MSR_BYTES_LONG           3'h4
`define MSR_BYTES_SHORT          3'h2
`define MSR_BYTES_CTRL           3'h2
// Control word upper-byte field positions
`define MSR_CTRL_FWD_BIT         4
`define MSR_CTRL_VEL_BIT         3
// Busy time after an accepted write
`define MSR_CLK_MHZ              40
`define MSR_BUSY_NS              100
`define MSR_BUSY_CYC             ((`MSR_BUSY_NS * `MSR_CLK_MHZ + 999) / 1000)
`endif

// *** design/msr_pkg.sv ***
// Types for the motion status and read-back block
package msr_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_WRITE, ST_READ} msr_seq_e;
  typedef struct packed {
    msr_seq_e    seq;
    logic [2:0]  left;
    logic [31:0] shreg;
    logic        pend_fwd;
    logic        pend_vel;
    logic [3:0]  busy_cnt;
    logic [5:0]  flags;     // 6 breakpoint .. 1 command error
    logic        traj_src;
    logic        host_int;
    logic        arm;
    logic        accel;
    logic        filt_upd;
    logic        fwd;
    logic        vel;
    logic        on_target;
    logic        stop_err;
    logic        eight;
    logic [31:0] idx_pos;
    logic [7:0]  db_out;
    logic        db_oe;
    logic        rd_act;
    logic        wr_act;
    logic        start;
  } msr_state_s;
endpackage

// *** testbench/msr_host_model.sv ***
// Host processor model for the parallel command, status and data port
`timescale 1ns/100ps
`default_nettype none
module msr_host_model (
  // Clock and read-back data
  input  wire logic       core_clk,
  input  wire logic [7:0] db_out,
  // Host strobes and write data
  output logic            cs_n,
  output logic            port_select_n,
  output logic            rd_n,
  output logic            wr_n,
  output logic      [7:0] db_in
);
  // Idle bus, data lines float as an arbitrary pattern
  initial begin
    cs_n = 1'b1;
    port_select_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    db_in = 8'hA5;
  end

  // One access; strobe held past the take edge, released a full cycle before the next
  task automatic acc(input logic w, input logic sel, input logic [7:0] d,
                     output logic [7:0] q);
    @(posedge core_clk);
    cs_n <= 1'b0;
    port_select_n <= sel;
    wr_n <= ~w;
    rd_n <= w;
    db_in <= w ? d : ~db_in;
    @(posedge core_clk);
    @(posedge core_clk);
    #1 q = db_out;
    @(posedge core_clk);
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    wr_n <= 1'b1;
    db_in <= ~db_in; // Released lines do not keep the old value
  endtask
endmodule
`default_nettype wire

// *** testbench/tb_motion_status_readback.sv ***
// Self-checking bench for status byte, signals word and read-back path
`timescale 1ns/100ps
`default_nettype none
module tb_motion_status_readback;
  logic        core_clk = 1'b0;
  logic        reset = 1'b1;
  logic        core_busy = 1'b0;
  logic        motor_off = 1'b0;
  logic [6:0]  ev = 7'h00;
  logic [5:0]  int_mask = 6'h00;
  logic [31:0] dpos = 32'h0, rpos = 32'h0, dvel = 32'h0, idx = 32'h0;
  logic [15:0] rvel = 16'h0;
  logic [7:0]  db_in, db_out, q, last;
  logic        cs_n, port_select_n, rd_n, wr_n, db_oe, host_int;
  logic        eight_bit_mode, stop_on_error, start_motion;
  logic [6:1]  fl = 6'h00;
  logic        hint = 0, arm = 0, accel = 0, fupd = 0, fwd = 0, vel = 0;
  logic        oe_exp = 1'b0;
  logic        ont = 0, stp = 0, eight = 1;
  int          failures = 0, total_checks = 0, starts = 0, seed = 46277;

  // Clock and start pulse counter
  always #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) if (start_motion === 1'b1) starts <= starts + 1;

  // Read enable trails the host strobes by one edge
  always @(posedge core_clk) oe_exp <= !reset && !cs_n && !rd_n;
  always @(negedge core_clk) if (!reset) chk(db_oe, oe_exp);

  msr_status_readback uut (
    .core_clk(core_clk), .reset(reset), .cs_n(cs_n), .port_select_n(port_select_n),
    .rd_n(rd_n), .wr_n(wr_n), .db_in(db_in), .db_out(db_out), .db_oe(db_oe),
    .host_int(host_int), .core_busy(core_busy), .index_pulse(ev[0]),
    .traj_done(ev[1]), .breakpoint_hit(ev[2]), .pos_error(ev[3]), .wraparound(ev[4]),
    .motor_off(motor_off), .accel_written(ev[5]), .sample_end(ev[6]),
    .int_mask(int_mask), .desired_pos(dpos), .real_pos(rpos), .desired_vel(dvel),
    .real_vel(rvel), .eight_bit_mode(eight_bit_mode), .stop_on_error(stop_on_error),
    .start_motion(start_motion));

  msr_host_model host (
    .core_clk(core_clk), .db_out(db_out), .cs_n(cs_n), .port_select_n(port_select_n),
    .rd_n(rd_n), .wr_n(wr_n), .db_in(db_in));

  // Reference model of status byte and signals word
  function automatic logic [7:0] stat(input logic b);
    return {motor_off, fl, b};
  endfunction
  function automatic logic [15:0] sig();
    return {hint, accel, fupd, fwd, vel, ont, stp, eight, motor_off, fl, arm};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Writes wait out the busy time before the next access
  task automatic wr(input logic sel, input logic [7:0] d);
    host.acc(1'b1, sel, d, q);
    repeat (4) @(posedge core_clk);
  endtask
  task automatic rd(input logic sel);
    host.acc(1'b0, sel, 8'h00, q);
  endtask
  task automatic rdn(input logic [7:0] c, input int n, input logic [31:0] v);
    wr(1'b0, c);
    for (int i = n - 1; i >= 0; i--) begin
      rd(1'b1);
      chk(q, v[8*i+:8]);
    end
  endtask
  task automatic pulse(input int b);
    @(posedge core_clk) ev[b] <= 1'b1;
    @(posedge core_clk) ev <= 7'h00;
    repeat (2) @(posedge core_clk);
  endtask

  task automatic report_and_stop();
    $display("checks=%0d failures=%0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Hang guard, generous against a run of well under a thousand cycles
  initial begin
    repeat (5000) @(posedge core_clk);
    failures++;
    report_and_stop();
  end

  // Main sequence
  initial begin
    repeat (8) @(posedge core_clk);
    reset <= 1'b0;
    dpos <= $random(seed);
    rpos <= $random(seed);
    dvel <= $random(seed);
    rvel <= 16'($random(seed));
    @(posedge core_clk);
    chk(eight_bit_mode, 1'b1);
    rd(1'b0);
    chk(q, stat(1'b0));
    rdn(8'h0C, 2, sig());
    rdn(8'h07, 4, dvel);
    rdn(8'h08, 4, dpos);
    rdn(8'h0A, 4, rpos);
    rdn(8'h0B, 2, rvel);
    // Index capture with its interrupt unmasked
    wr(1'b0, 8'h03);
    arm = 1'b1;
    rdn(8'h0C, 2, sig());
    @(posedge core_clk) int_mask <= 6'h04;
    pulse(0);
    idx = rpos;
    fl[3] = 1'b1;
    arm = 1'b0;
    hint = 1'b1;
    chk(host_int, hint);
    rdn(8'h0C, 2, sig());
    rdn(8'h09, 4, idx);
    wr(1'b0, 8'h1D);
    fl = 6'h00;
    hint = 1'b0;
    chk(host_int, hint);
    rd(1'b0);
    chk(q, stat(1'b0));
    // Flags still latch with every condition masked
    @(posedge core_clk) int_mask <= 6'h00;
    for (int b = 2; b <= 4; b++) pulse(b);
    fl[6:4] = 3'h7;
    rd(1'b0);
    chk(q, stat(1'b0));
    chk(host_int, 1'b0);
    wr(1'b0, 8'h1D);
    fl = 6'h00;
    // Trajectory load, start and completion
    pulse(5);
    accel = 1'b1;
    wr(1'b0, 8'h1F);
    wr(1'b1, 8'h18);
    wr(1'b1, 8'h00);
    rdn(8'h0C, 2, sig());
    wr(1'b0, 8'h01);
    {fwd, vel, accel} = 3'b110;
    chk(starts, 1);
    rdn(8'h0C, 2, sig());
    pulse(1);
    ont = 1'b1;
    fl[2] = 1'b1;
    rd(1'b0);
    chk(q, stat(1'b0));
    wr(1'b0, 8'h01);
    ont = 1'b0;
    rdn(8'h0C, 2, sig());
    // Wrong-direction access, then a new command breaks into the sequence
    @(posedge core_clk) int_mask <= 6'h01;
    wr(1'b0, 8'h1F);
    rd(1'b1);
    fl[1] = 1'b1;
    hint = 1'b1;
    rd(1'b0);
    chk(q, stat(1'b0));
    chk(host_int, hint);
    wr(1'b0, 8'h03);
    arm = 1'b1;
    rdn(8'h0C, 2, sig());
    wr(1'b0, 8'h1D);
    fl = 6'h00;
    hint = 1'b0;
    // Command and data accesses while busy are refused quietly; a status read still answers
    @(posedge core_clk) core_busy <= 1'b1;
    wr(1'b0, 8'h06);
    last = q;
    rd(1'b1);
    chk(q, last);
    rd(1'b0);
    chk(q, stat(1'b1));
    @(posedge core_clk) core_busy <= 1'b0;
    chk(eight_bit_mode, 1'b1);
    // Mode commands
    wr(1'b0, 8'h06);
    chk(eight_bit_mode, 1'b0);
    wr(1'b0, 8'h05);
    chk(eight_bit_mode, 1'b1);
    wr(1'b0, 8'h1A);
    stp = 1'b1;
    chk(stop_on_error, 1'b1);
    rdn(8'h0C, 2, sig());
    wr(1'b0, 8'h1B);
    stp = 1'b0;
    chk(stop_on_error, 1'b0);
    // Filter update flag lives one sample interval
    wr(1'b0, 8'h04);
    fupd = 1'b1;
    rdn(8'h0C, 2, sig());
    pulse(6);
    fupd = 1'b0;
    rdn(8'h0C, 2, sig());
    // Motor off also marks the trajectory complete
    @(posedge core_clk) motor_off <= 1'b1;
    repeat (2) @(posedge core_clk);
    fl[2] = 1'b1;
    rd(1'b0);
    chk(q, stat(1'b0));
    rdn(8'h0C, 2, sig());
    report_and_stop();
  end
endmodule
`default_nettype wire
